/* File: hw/atc_defs.svh */
// Register offsets, field positions and fixed cell constants
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH
`define ATC_OFS_CTRL 8'h00
`define ATC_OFS_CMD 8'h04
`define ATC_OFS_STAT 8'h08
`define ATC_OFS_MASK 8'h0C
`define ATC_OFS_DFLAG 8'h10
`define ATC_PAGE_DESC 4'h2
`define ATC_PAGE_HEAD 4'h4
`define ATC_CMD_HALT 0
`define ATC_CMD_RESYNC 1
`define ATC_ST_UNDER 4
`define ATC_ST_OVER 5
`define ATC_MASK_RST 32'hFFFF_FFFF
`define ATC_IDLE_HDR 32'h0000_0001
`define ATC_IDLE_PAY 8'h6A
`define ATC_HEC_POLY 8'h07
`define ATC_HEC_COSET 8'h55
`define ATC_HDR_LAST 6'h04
`define ATC_PAY_FIRST 6'h05
`define ATC_CELL_LAST 6'h34
`define ATC_BIT_LAST 3'h7
`define ATC_ALPHA 3'h7
`define ATC_DELTA 3'h6
`define ATC_SCR_LEN 43
`endif

/* File: hw/atc_pkg.sv */
// Types shared by the cell transmission-convergence block
package atc_pkg;
   typedef enum logic [1:0] {
      DL_HUNT = 2'b00,
      DL_PRESYNC = 2'b01,
      DL_SYNC = 2'b11
   } atc_delin_t;
   typedef struct packed {
      logic camEn;
      logic scrEn;
      logic rxEn;
      logic txEn;
   } atc_ctrl_t;
   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic last;
      logic camOk;
   } atc_rxbyte_t;
endpackage

/* File: hw/atc_cell_tc.sv */
// Cell transmit, delineation, filtering and payload scrambling over APB
//Contract
// - Start sends one idle cell first
// - Bypass descriptor: idle cell, advance
// - Ready sends user cell, else idle
// - Stop on halt, underrun or disable
// - Optional x^43+1 payload scramble, header clear
// - Scrambler state spans cells, ignores connection
// - Delineate first, store only afterwards
// - Bad HEC cells still stored in sync
// - Idle cell payloads are discarded
// - Store only on header table match, any user cell in CAM mode
// - CAM mode: store first, match after
// - Receive until overrun or disable; resync only restarts hunt
// - Alpha seven, delta six
// - Hunt: CRC of word versus next byte
// - Word search may take four cells
// - Presync: bad HEC or resync to hunt
// - Sixth good HEC: sync, store that cell
// - Seventh bad HEC: hunt, cell dropped
// - Resync in sync returns to hunt
// - Descrambler self-synchronises within 43 bits
// - Resync waits for current cell end in presync and sync; in hunt it restarts the search at once
`timescale 1ns/10ps
`include "atc_defs.svh"
module atc_cell_tc import atc_pkg::*; #(
   parameter int NDESC = 4,
   parameter int NHEAD = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lineClk,
   input wire logic lineRxd,
   output logic lineTxd,
   input wire logic camMatch,
   input wire logic [7:0] txData,
   input wire logic txValid,
   output logic txReady,
   output atc_rxbyte_t rxByte,
   output logic rxValid,
   input wire logic rxReady
);
   function automatic logic [7:0] atcHec(input logic [31:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `ATC_HEC_POLY : 8'h00);
      end
      return c ^ `ATC_HEC_COSET;
   endfunction

   function automatic logic [7:0] atcCellByte(input logic [5:0] idx,
      input logic [31:0] hdr, input logic user, input logic [7:0] pay);
      logic [7:0] b;
      case (idx)
         6'h00: b = hdr[31:24];
         6'h01: b = hdr[23:16];
         6'h02: b = hdr[15:8];
         6'h03: b = hdr[7:0];
         `ATC_HDR_LAST: b = atcHec(hdr);
         default: b = user ? pay : `ATC_IDLE_PAY;
      endcase
      return b;
   endfunction

   // Pin synchronisers; first stage only feeds second
   logic [1:0] clkSync, rxdSync, camSync;
   logic clkPrev;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clkSync <= 2'b00;
         rxdSync <= 2'b00;
         camSync <= 2'b00;
         clkPrev <= 1'b0;
      end else begin
         clkSync <= {clkSync[0], lineClk};
         rxdSync <= {rxdSync[0], lineRxd};
         camSync <= {camSync[0], camMatch};
         clkPrev <= clkSync[1];
      end
   end
   wire lineRise = clkSync[1] & ~clkPrev;
   wire rxBit = rxdSync[1];

   // Register file
   atc_ctrl_t ctrl;
   logic [31:0] headMask;
   logic [2*NDESC-1:0] descFlags;
   logic [31:0] descHdr [NDESC];
   logic [31:0] headTab [NHEAD];
   logic underrun, overrun, haltPend, resyncPend;
   logic [31:0] rdNext;

   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire pageDesc = paddr[7:4] == `ATC_PAGE_DESC;
   wire pageHead = paddr[7:4] == `ATC_PAGE_HEAD;
   wire [1:0] slot = paddr[3:2];
   wire slotDesc = 32'(slot) < NDESC;
   wire slotHead = 32'(slot) < NHEAD;
   wire hitFix = paddr == `ATC_OFS_CTRL || paddr == `ATC_OFS_CMD
      || paddr == `ATC_OFS_STAT || paddr == `ATC_OFS_MASK
      || paddr == `ATC_OFS_DFLAG;
   wire mapped = paddr[1:0] == 2'b00
      && (hitFix || (pageDesc && slotDesc) || (pageHead && slotHead));
   wire cmdWr = wr && mapped && paddr == `ATC_OFS_CMD;
   wire stWr = wr && mapped && paddr == `ATC_OFS_STAT;

   // Transmit state
   logic txRun, txStop, txUser, txBufFull;
   logic [31:0] txHdr;
   logic [5:0] txByteCnt;
   logic [2:0] txBitCnt;
   logic [7:0] txShift, txBuf;
   logic [`ATC_SCR_LEN-1:0] tScr;
   logic [$clog2(NDESC)-1:0] dIdx;
   // Receive state
   atc_delin_t dl;
   logic rxRun, rxStop, rxFill, rxStore;
   logic [1:0] huntCnt;
   logic [5:0] rxByteCnt;
   logic [2:0] rxBitCnt, goodCnt, badCnt;
   logic [39:0] rxWin;
   logic [7:0] rxDesc;
   logic [`ATC_SCR_LEN-1:0] rScr;

   always_comb begin
      rdNext = 32'h0000_0000;
      if (pageDesc) begin
         rdNext = descHdr[slot];
      end else if (pageHead) begin
         rdNext = headTab[slot];
      end else begin
         case (paddr)
            `ATC_OFS_CTRL: rdNext = {28'h000_0000, ctrl};
            `ATC_OFS_STAT: rdNext = {26'h000_0000, overrun, underrun,
               rxRun, txRun, dl};
            `ATC_OFS_MASK: rdNext = headMask;
            `ATC_OFS_DFLAG: rdNext = 32'(descFlags);
            default: rdNext = 32'h0000_0000;
         endcase
      end
   end

   // APB: one wait state, unmapped answers pslverr
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata <= (psel & penable & ~pready & mapped & ~pwrite)
            ? rdNext : 32'h0000_0000;
      end
   end

   // Transmit cell selection
   wire [1:0] curFlags = descFlags[2*dIdx +: 2];
   wire txGo = ctrl.txEn & ~txStop;
   wire txCellEnd = txBitCnt == `ATC_BIT_LAST
      && txByteCnt == `ATC_CELL_LAST;
   wire startCell = lineRise & ~txRun & txGo;
   wire nextCell = lineRise & txRun & txCellEnd & txGo & ~haltPend;
   wire pickUser = nextCell & ~curFlags[1] & curFlags[0];
   wire advance = nextCell & (curFlags[1] | curFlags[0]);
   wire [31:0] newHdr = pickUser ? descHdr[dIdx] : `ATC_IDLE_HDR;
   wire [5:0] txNextIdx = txByteCnt + 6'h01;
   wire needPay = txUser && txNextIdx >= `ATC_PAY_FIRST;
   wire txStarve = lineRise & txRun & txBitCnt == `ATC_BIT_LAST
      & ~txCellEnd & needPay & ~txBufFull;
   wire txScr = ctrl.scrEn & (txByteCnt >= `ATC_PAY_FIRST);
   wire txRaw = txShift[3'h7 - txBitCnt];
   wire txOut = txRaw ^ (txScr & tScr[`ATC_SCR_LEN-1]);
   wire txTake = txValid & txReady;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         txRun <= 1'b0;
         txStop <= 1'b0;
         txUser <= 1'b0;
         txHdr <= `ATC_IDLE_HDR;
         txByteCnt <= 6'h00;
         txBitCnt <= 3'h0;
         txShift <= 8'h00;
         tScr <= '0;
         lineTxd <= 1'b1;
         dIdx <= '0;
      end else begin
         if (ctrl.txEn == 1'b0) begin
            txStop <= 1'b0;
         end
         if (startCell) begin
            txRun <= 1'b1;
            txUser <= 1'b0;
            txHdr <= `ATC_IDLE_HDR;
            txByteCnt <= 6'h00;
            txBitCnt <= 3'h0;
            txShift <= atcCellByte(6'h00, `ATC_IDLE_HDR, 1'b0, txBuf);
         end else if (lineRise && txRun) begin
            lineTxd <= txOut;
            if (txScr) begin
               tScr <= {tScr[`ATC_SCR_LEN-2:0], txOut};
            end
            txBitCnt <= txBitCnt + 3'h1;
            if (txBitCnt == `ATC_BIT_LAST) begin
               txByteCnt <= txNextIdx;
               txShift <= atcCellByte(txNextIdx, txHdr, txUser, txBuf);
               if (txStarve || (txCellEnd && !nextCell)) begin
                  txRun <= 1'b0;
                  txStop <= txStop | txStarve | haltPend;
               end else if (txCellEnd) begin
                  txUser <= pickUser;
                  txHdr <= newHdr;
                  txByteCnt <= 6'h00;
                  txShift <= atcCellByte(6'h00, newHdr, pickUser, txBuf);
               end
            end
         end
         if (advance) begin
            dIdx <= (32'(dIdx) == NDESC - 1) ? '0 : dIdx + 1'b1;
         end
         if (!ctrl.txEn) begin
            txRun <= 1'b0;
            lineTxd <= 1'b1;
         end else if (!txRun) begin
            lineTxd <= 1'b1;
         end
      end
   end

   // Payload prefetch from the user stream; stalls source via txReady
   always_ff @(posedge clk) begin
      if (!nrst) begin
         txBuf <= 8'h00;
         txBufFull <= 1'b0;
         txReady <= 1'b0;
      end else begin
         if (txTake) begin
            txBuf <= txData;
            txBufFull <= 1'b1;
         end else if (lineRise && txRun && txBitCnt == `ATC_BIT_LAST
               && needPay && !txCellEnd) begin
            txBufFull <= 1'b0;
         end
         txReady <= txRun & txUser & ~txBufFull & ~txTake
            & (txByteCnt != `ATC_CELL_LAST);
      end
   end

   // Receive: header lookup table
   logic [NHEAD-1:0] headHit;
   genvar g;
   generate
      for (g = 0; g < NHEAD; g++) begin : gHead
         assign headHit[g] =
            ((rxWin[38:7] ^ headTab[g]) & headMask) == 32'h0000_0000;
      end
   endgenerate

   wire [39:0] winNow = {rxWin[38:0], rxBit};
   wire byteDone = rxBitCnt == `ATC_BIT_LAST;
   wire hecOk = atcHec(winNow[39:8]) == winNow[7:0];
   wire isIdle = winNow[39:8] == `ATC_IDLE_HDR;
   wire inHdr = dl != DL_HUNT && rxByteCnt <= `ATC_HDR_LAST;
   wire rxScr = ctrl.scrEn & ~inHdr;
   wire rxD = rxBit ^ (rxScr & rScr[`ATC_SCR_LEN-1]);
   wire rxGo = ctrl.rxEn & ~rxStop;
   wire rxStep = lineRise & rxRun;
   wire rxHdrDone = rxStep && byteDone && dl != DL_HUNT
      && rxByteCnt == `ATC_HDR_LAST;
   wire rxCellEnd = rxStep && byteDone && dl != DL_HUNT
      && rxByteCnt == `ATC_CELL_LAST;
   // word then next byte, aligned search
   wire huntHit = rxStep && byteDone && dl == DL_HUNT
      && huntCnt == 2'b00 && rxFill && hecOk;
   // table hit, CAM mode stores every user cell
   wire keep = ~isIdle & (|headHit | ctrl.camEn);
   wire payByte = rxStep && byteDone && rxStore
      && rxByteCnt >= `ATC_PAY_FIRST;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dl <= DL_HUNT;
         rxRun <= 1'b0;
         rxStop <= 1'b0;
         rxFill <= 1'b0;
         rxStore <= 1'b0;
         huntCnt <= 2'b00;
         rxByteCnt <= 6'h00;
         rxBitCnt <= 3'h0;
         goodCnt <= 3'h0;
         badCnt <= 3'h0;
         rxWin <= '0;
         rxDesc <= 8'h00;
         rScr <= '0;
      end else begin
         if (!ctrl.rxEn) begin
            rxStop <= 1'b0;
         end
         rxRun <= rxGo;
         if (rxStep) begin
            rxWin <= winNow;
            rxDesc <= {rxDesc[6:0], rxD};
            if (rxScr) begin
               rScr <= {rScr[`ATC_SCR_LEN-2:0], rxBit};
            end
            rxBitCnt <= rxBitCnt + 3'h1;
            if (byteDone) begin
               huntCnt <= huntCnt + 2'b01;
               if (huntCnt == 2'b11) begin
                  rxFill <= 1'b1;
               end
               rxByteCnt <= (rxByteCnt == `ATC_CELL_LAST) ? 6'h00
                  : rxByteCnt + 6'h01;
            end
         end
         if (huntHit) begin
            dl <= DL_PRESYNC;
            rxByteCnt <= `ATC_PAY_FIRST;
            goodCnt <= 3'h0;
         end
         if (rxHdrDone) begin
            rxStore <= 1'b0;
            if (dl == DL_PRESYNC) begin
               // one bad HEC, sixth good enters sync
               if (!hecOk) begin
                  dl <= DL_HUNT;
               end else if (goodCnt + 3'h1 == `ATC_DELTA) begin
                  dl <= DL_SYNC;
                  badCnt <= 3'h0;
                  rxStore <= keep;
               end else begin
                  goodCnt <= goodCnt + 3'h1;
               end
            end else if (!hecOk && badCnt + 3'h1 == `ATC_ALPHA) begin
               dl <= DL_HUNT;
            end else begin
               // bad HEC cell still kept, idle dropped
               badCnt <= hecOk ? 3'h0 : badCnt + 3'h1;
               rxStore <= keep;
            end
         end
         // resync acted at cell end, from sync too
         if (rxCellEnd) begin
            rxStore <= 1'b0;
            if (resyncPend) begin
               dl <= DL_HUNT;
            end
         end
         if (payByte && rxValid && !rxReady) begin
            rxStop <= 1'b1;
         end
         if (!rxRun || (dl == DL_HUNT && resyncPend)
               || (rxHdrDone && dl == DL_PRESYNC && !hecOk)
               || (rxCellEnd && resyncPend)) begin
            if (!rxRun || dl == DL_HUNT) begin
               dl <= DL_HUNT;
            end
            huntCnt <= 2'b00;
            rxFill <= 1'b0;
            rxBitCnt <= rxRun ? rxBitCnt + {2'b00, rxStep} : 3'h0;
            rxStore <= 1'b0;
         end
      end
   end

   // Received payload stream; a byte not taken before the next is overrun
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rxByte <= '0;
         rxValid <= 1'b0;
      end else if (payByte) begin
         rxValid <= 1'b1;
         rxByte.data <= {rxDesc[6:0], rxD};
         rxByte.first <= rxByteCnt == `ATC_PAY_FIRST;
         rxByte.last <= rxByteCnt == `ATC_CELL_LAST;
         rxByte.camOk <= ~ctrl.camEn | camSync[1];
      end else if (rxReady) begin
         rxValid <= 1'b0;
      end
   end

   // Software registers, commands and sticky errors
   logic [2*NDESC-1:0] flagClr;
   always_comb begin
      flagClr = '0;
      if (pickUser) begin
         flagClr[2*dIdx] = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= '0;
         headMask <= `ATC_MASK_RST;
         descFlags <= '0;
         underrun <= 1'b0;
         overrun <= 1'b0;
         haltPend <= 1'b0;
         resyncPend <= 1'b0;
         for (int i = 0; i < NDESC; i++) begin
            descHdr[i] <= 32'h0000_0000;
         end
         for (int i = 0; i < NHEAD; i++) begin
            headTab[i] <= 32'h0000_0000;
         end
      end else begin
         if (wr && mapped && paddr == `ATC_OFS_CTRL) begin
            ctrl <= pwdata[3:0];
         end
         if (wr && mapped && paddr == `ATC_OFS_MASK) begin
            headMask <= pwdata;
         end
         if (wr && pageDesc && slotDesc) begin
            descHdr[slot] <= pwdata;
         end
         if (wr && pageHead && slotHead) begin
            headTab[slot] <= pwdata;
         end
         // Consumed descriptor hands ready back to software
         descFlags <= ((wr && mapped && paddr == `ATC_OFS_DFLAG)
            ? pwdata[2*NDESC-1:0] : descFlags) & ~flagClr;
         haltPend <= (haltPend & txRun)
            | (cmdWr & pwdata[`ATC_CMD_HALT]);
         resyncPend <= (resyncPend & ~rxCellEnd & rxRun & dl != DL_HUNT)
            | (cmdWr & pwdata[`ATC_CMD_RESYNC]);
         // Hardware set wins over write-one-to-clear
         underrun <= txStarve
            | (underrun & ~(stWr & pwdata[`ATC_ST_UNDER]));
         overrun <= (payByte & rxValid & ~rxReady)
            | (overrun & ~(stWr & pwdata[`ATC_ST_OVER]));
      end
   end
   wire unusedRd = rd;
endmodule

/* File: tb/atc_cell_tc_properties.sv */
// Port-level checks for the cell block, bound into every instance
`timescale 1ns/10ps
module atc_cell_tc_properties import atc_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic lineClk,
   input wire logic lineTxd,
   input wire logic txValid,
   input wire logic txReady,
   input wire atc_rxbyte_t rxByte,
   input wire logic rxValid,
   input wire logic rxReady
);
   logic lineClkQ;
   logic [3:0] sinceRise;
   logic [3:0] next_sinceRise;
   logic [5:0] byteCnt;
   // Saturates so a stalled line clock cannot wrap the count
   assign next_sinceRise = (lineClk && !lineClkQ) ? 4'h0 :
      (sinceRise == 4'hF) ? sinceRise : sinceRise + 4'h1;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lineClkQ <= 1'b0;
         sinceRise <= 4'hF;
      end else begin
         lineClkQ <= lineClk;
         sinceRise <= next_sinceRise;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) byteCnt <= 6'h00;
      else if (rxValid && rxReady) byteCnt <= rxByte.last ? 6'h00 :
         byteCnt + 6'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_reset; $rose(nrst) |-> lineTxd && !rxValid && !txReady; endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   property p_wait; psel && $rose(penable) |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("pready not one wait");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_phase; pready |-> psel && penable; endproperty
   a_phase: assert property (p_phase) else $error("pready outside access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_zero; !pready |-> prdata == 32'h0000_0000; endproperty
   a_zero: assert property (p_zero) else $error("prdata not zero");
   property p_txd; $changed(lineTxd) |-> sinceRise < 4'h7; endproperty
   a_txd: assert property (p_txd) else $error("tx bit off line edge");
   property p_txrdy; txReady && txValid |=> !txReady; endproperty
   a_txrdy: assert property (p_txrdy) else $error("txReady held");
   property p_first; rxValid && rxReady && rxByte.first |-> byteCnt == 6'h00;
   endproperty
   a_first: assert property (p_first) else $error("first misplaced");
   property p_last; rxValid && rxReady && rxByte.last |-> byteCnt == 6'h2F;
   endproperty
   a_last: assert property (p_last) else $error("cell not 48 bytes");
   property p_rxdrop; rxValid && rxReady |=> !rxValid; endproperty
   a_rxdrop: assert property (p_rxdrop) else $error("rxValid held");
endmodule
bind atc_cell_tc atc_cell_tc_properties i_chk (.clk, .nrst, .psel,
   .penable, .prdata, .pready, .pslverr, .lineClk, .lineTxd, .txValid,
   .txReady, .rxByte, .rxValid, .rxReady);

/* File: tb/atc_line_model.sv */
// Far-end line: free-running bit clock, echoes transmit onto receive
`timescale 1ns/10ps
module atc_line_model (
   input wire logic lineTxd,
   input wire logic corrupt,
   output logic lineClk,
   output logic lineRxd
);
   initial begin
      lineClk = 1'b0;
      lineRxd = 1'b1;
      #5;
      forever #32 lineClk = ~lineClk;
   end
   // Echo on the fall so the bit is settled at the sampling rise
   always @(negedge lineClk) lineRxd <= lineTxd ^ corrupt;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench: registers, delineation and looped-back cells
`timescale 1ns/10ps
`include "atc_defs.svh"
module testbench import atc_pkg::*;;
   localparam logic [31:0] HDR = 32'h0012_3450;
   localparam logic [7:0] DESC0 = {`ATC_PAGE_DESC, 4'h0};
   localparam logic [7:0] DESC2 = {`ATC_PAGE_DESC, 4'h8};
   localparam logic [7:0] TAB0 = {`ATC_PAGE_HEAD, 4'h0};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, lineClk, lineRxd, lineTxd, txReady, rxValid;
   logic camMatch = 1'b0;
   logic [7:0] txData = 8'h00;
   logic txValid = 1'b1;
   logic rxReady = 1'b1;
   logic corrupt = 1'b0;
   logic sawPre = 1'b0;
   atc_rxbyte_t rxByte;
   atc_rxbyte_t got[$];
   logic [31:0] rq;
   logic re;
   int failures = 0;
   int compares = 0;
   atc_cell_tc i_dut (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lineClk(lineClk), .lineRxd(lineRxd), .lineTxd(lineTxd),
      .camMatch(camMatch), .txData(txData), .txValid(txValid),
      .txReady(txReady), .rxByte(rxByte), .rxValid(rxValid),
      .rxReady(rxReady));
   atc_line_model i_line (.lineTxd(lineTxd), .corrupt(corrupt),
      .lineClk(lineClk), .lineRxd(lineRxd));
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (txValid && txReady === 1'b1) txData <= txData + 8'h01;
      if (rxValid === 1'b1 && rxReady) got.push_back(rxByte);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic poll(input logic [1:0] st, input int lim);
      int n;
      n = 0;
      rd(`ATC_OFS_STAT);
      while (rq[1:0] !== st && n < lim) begin
         if (rq[1:0] === DL_PRESYNC) sawPre = 1'b1;
         rd(`ATC_OFS_STAT);
         n++;
      end
   endtask
   task automatic t_regs();
      rd(`ATC_OFS_MASK);
      check(rq, `ATC_MASK_RST);
      rd(`ATC_OFS_STAT);
      check(rq, 32'h0);
      wr(TAB0, HDR);
      rd(TAB0);
      check(rq, HDR);
      wr(8'h30, 32'hFFFF_FFFF);
      check(32'(re), 32'h1);
      rd(8'h30);
      check(32'(re), 32'h1);
      check(rq, 32'h0);
   endtask
   task automatic t_sync();
      // Transmit first; the receiver starts on an octet boundary,
      // as the framed line would deliver it after a loopback
      wr(`ATC_OFS_CTRL, 32'h5);
      while (lineTxd !== 1'b0) begin
         @(posedge clk);
      end
      wr(`ATC_OFS_CTRL, 32'h7);
      poll(DL_SYNC, 12000);
      check(32'(rq[1:0]), 32'(DL_SYNC));
      check(32'(sawPre), 32'h1);
      check(32'(rq[3:2]), 32'h3);
      check(32'(got.size()), 32'h0);
   endtask
   task automatic t_cells();
      int n;
      n = 0;
      got.delete();
      wr(DESC0, HDR);
      wr(DESC2, HDR);
      wr(`ATC_OFS_DFLAG, 32'h19);
      while (got.size() < 96 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      // Idle polling afterwards must deliver nothing more
      repeat (3500) @(posedge clk);
      check(32'(got.size()), 32'd96);
      foreach (got[i]) begin
         check(32'(got[i].data), 32'(i[7:0]));
         check(32'(got[i].first), 32'(i % 48 == 0));
         check(32'(got[i].last), 32'(i % 48 == 47));
         check(32'(got[i].camOk), 32'h1);
      end
      rd(`ATC_OFS_DFLAG);
      check(rq & 32'h11, 32'h0);
   endtask
   task automatic t_lose();
      corrupt <= 1'b1;
      // Three cell times leaves at most four bad cells
      repeat (10176) @(posedge clk);
      rd(`ATC_OFS_STAT);
      check(32'(rq[1:0]), 32'(DL_SYNC));
      poll(DL_HUNT, 5000);
      check(32'(rq[1:0]), 32'(DL_HUNT));
      corrupt <= 1'b0;
   endtask
   task automatic wrap_up();
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_sync();
      t_cells();
      t_lose();
      wrap_up();
   end
   initial begin
      repeat (95000) @(posedge clk);
      failures++;
      wrap_up();
   end
endmodule
